// ==== lcd_source_driver_host_command_port_test.sv ====
// Self-checking testbench of the host command port
module lcd_source_driver_host_command_port_test;
	timeunit 1ns;
	timeprecision 1ns;

	// Host only touches mapped indexes and one index outside the map
	localparam logic [7:0] RW_A [33] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
		8'h0f, 8'h10, 8'h11, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h1d, 8'h1e, 8'h1f,
		8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2a, 8'h2d, 8'h2e, 8'h31, 8'h72, 8'h73};

	logic        clk_sys, resetn, cs_n, rs, rd_n_en, wr_n_dir, ser_clk, ser_data;
	logic        pixel_stb, command_reset_stb;
	logic [1:0]  if_sel;
	logic [3:0]  gp_in;
	logic [15:0] db_in, db_out, db_oe, pixel_data, last_pix, v, w;
	logic [7:0]  control_one, control_two, data_access_control, gp_out, register_pointer;
	logic [7:0]  sh [128];
	int          errors, checked, cyc, pix_cnt, cr_cnt, seed, i, n, k, n0;

	lcdhp_port #(.IN_W(4)) dut (.clk_sys(clk_sys), .resetn(resetn), .if_sel(if_sel), .cs_n(cs_n),
		.register_select_line(rs), .rd_n_en(rd_n_en), .wr_n_dir(wr_n_dir), .db_in(db_in),
		.db_out(db_out), .db_oe(db_oe), .ser_clk(ser_clk), .ser_data(ser_data), .gp_in(gp_in),
		.control_one(control_one), .control_two(control_two), .data_access_control(data_access_control),
		.gp_out(gp_out), .pixel_data(pixel_data), .pixel_stb(pixel_stb),
		.command_reset_stb(command_reset_stb), .register_pointer(register_pointer));

	lcdhp_host_model host (.clk_sys(clk_sys), .if_sel(if_sel), .cs_n(cs_n), .rs(rs), .rd_n_en(rd_n_en),
		.wr_n_dir(wr_n_dir), .db_in(db_in), .db_out(db_out), .ser_clk(ser_clk), .ser_data(ser_data));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// ********
	// Monitors and helpers
	// ********
	// Strobes stand one cycle, so they are counted mid-cycle where they have settled
	always @(negedge clk_sys) begin
		cyc++;
		if (pixel_stb === 1'b1) begin
			pix_cnt++;
			last_pix = pixel_data;
		end
		if (command_reset_stb === 1'b1) cr_cnt++;
		if (cyc == 30000) begin
			errors++;
			close_out;
		end
	end

	function automatic logic is_rw(input logic [7:0] a);
		foreach (RW_A[j]) if (RW_A[j] == a) return 1'b1;
		return 1'b0;
	endfunction

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		if (is_rw(a)) return sh[a[6:0]];
		if (a == 8'h03 || a == 8'h0c) return 8'hff;
		if (a == 8'h32) return {4'h0, gp_in};
		return 8'h00;
	endfunction

	task shadow_init;
		foreach (sh[j]) sh[j] = 8'h00;
		sh[7'h2e] = 8'h06;
	endtask

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wreg(input logic [7:0] a, input logic [15:0] d);
		host.wr(1'b0, {d[15:8], a});
		host.wr(1'b1, d);
		if (is_rw(a)) sh[a[6:0]] = d[7:0];
	endtask

	task rreg(input logic [7:0] a);
		host.wr(1'b0, {w[15:8], a});
		host.rd(v);
		chk("read data", {8'h00, exp_rd(a)}, v);
		chk("drive enable", 16'hffff, db_oe);
		repeat (2) @(negedge clk_sys);
		chk("release", 16'h0000, db_oe);
	endtask

	// Narrow pairing sends the high byte first; serial always pairs
	task pix(input logic bw);
		wreg(8'h05, {8'h00, bw, 7'h00});
		w = 16'($random(seed));
		n0 = pix_cnt;
		host.wr(1'b0, 16'h000c);
		if (bw || if_sel == 2'h2) begin
			host.wr(1'b1, {~w[15:8], w[15:8]});
			repeat (2) @(negedge clk_sys);
			chk("half pixel", 16'(n0), 16'(pix_cnt));
			host.wr(1'b1, {~w[7:0], w[7:0]});
		end else begin
			host.wr(1'b1, w);
		end
		repeat (2) @(negedge clk_sys);
		chk("pixel count", 16'(n0 + 1), 16'(pix_cnt));
		chk("pixel word", w, last_pix);
	endtask

	task close_out;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		seed = 32'hfd9e;
		resetn = 1'b0;
		if_sel = 2'h0;
		gp_in = 4'h0;
		w = 16'h0000;
		repeat (10) @(negedge clk_sys);
		resetn = 1'b1;
		shadow_init;
		chk("pointer", 16'h0000, {8'h00, register_pointer});
		for (i = 0; i < 33; i++) rreg(RW_A[i]);
		for (n = 0; n < 2; n++) begin
			@(negedge clk_sys);
			if_sel = n[1:0];
			host.idle;
			gp_in = 4'($random(seed));
			for (i = 0; i < 30; i++) begin
				w = 16'($random(seed));
				k = {$random(seed)} % 33;
				wreg(RW_A[k], w);
				rreg(RW_A[k]);
			end
			// Wide bus first, so the junk on the upper lines must not land
			wreg(8'h05, 16'h0000);
			wreg(8'h31, {~w[7:0], w[7:0]});
			chk("control_one", {8'h00, sh[0]}, {8'h00, control_one});
			chk("control_two", {8'h00, sh[1]}, {8'h00, control_two});
			chk("data access", {8'h00, sh[5]}, {8'h00, data_access_control});
			chk("output port", {8'h00, sh[7'h31]}, {8'h00, gp_out});
			rreg(8'h03);
			rreg(8'h0c);
			wreg(8'h32, w);
			rreg(8'h32);
			rreg(8'h7f);
			pix(1'b0);
			pix(1'b1);
		end
		@(negedge clk_sys);
		if_sel = 2'h2;
		host.idle;
		w = 16'($random(seed));
		wreg(8'h00, w);
		chk("serial byte", {8'h00, sh[0]}, {8'h00, control_one});
		pix(1'b0);
		@(negedge clk_sys);
		if_sel = 2'h0;
		host.idle;
		rreg(8'h00);
		wreg(8'h2e, 16'h00a5);
		n0 = cr_cnt;
		wreg(8'h03, 16'h0001);
		repeat (2) @(negedge clk_sys);
		chk("reset pulse", 16'(n0 + 1), 16'(cr_cnt));
		chk("pointer", 16'h0000, {8'h00, register_pointer});
		shadow_init;
		w = 16'($random(seed));
		wreg(8'h01, w);
		chk("control_two", {8'h00, sh[1]}, {8'h00, control_two});
		rreg(8'h2e);
		rreg(8'h03);
		close_out;
	end
endmodule

// ==== lcdhp_byte_if.sv ====
// Carrier of assembled serial bytes from the shifter to the command decoder
interface lcdhp_byte_if;
	logic [7:0] data;
	logic       rs;
	logic       valid;

	modport src (
		output data,
		output rs,
		output valid
	);

	modport snk (
		input data,
		input rs,
		input valid
	);
endinterface

// ==== lcdhp_defs.svh ====
// Register offsets, field positions and reset values of the host command port
`ifndef LCDHP_DEFS_SVH
`define LCDHP_DEFS_SVH

// ****************************************
// Register offsets (index values)
// ****************************************
`define LCDHP_A_CONTROL_ONE        8'h00
`define LCDHP_A_CONTROL_TWO        8'h01
`define LCDHP_A_CMD_RESET          8'h03
`define LCDHP_A_DATA_ACCESS        8'h05
`define LCDHP_A_COLUMN_PTR         8'h06
`define LCDHP_A_LINE_PTR           8'h07
`define LCDHP_A_WIN_COL_LOW        8'h08
`define LCDHP_A_WIN_COL_HIGH       8'h09
`define LCDHP_A_WIN_LINE_LOW       8'h0a
`define LCDHP_A_WIN_LINE_HIGH      8'h0b
`define LCDHP_A_PIXEL_PORT         8'h0c
`define LCDHP_A_SCROLL_FIRST       8'h0f
`define LCDHP_A_SCROLL_TOTAL       8'h10
`define LCDHP_A_SCROLL_STEP        8'h11
`define LCDHP_A_BLANK_COLOUR       8'h13
`define LCDHP_A_PART1_FIRST        8'h14
`define LCDHP_A_PART2_FIRST        8'h15
`define LCDHP_A_PART1_TOTAL        8'h16
`define LCDHP_A_PART2_TOTAL        8'h17
`define LCDHP_A_SUPPLY_ONE         8'h19
`define LCDHP_A_SUPPLY_TWO         8'h1a
`define LCDHP_A_COMMON_CENTRE      8'h1d
`define LCDHP_A_DRIVE_STRENGTH     8'h1e
`define LCDHP_A_GAMMA_REF          8'h1f
`define LCDHP_A_GAMMA_C1           8'h24
`define LCDHP_A_GAMMA_C2           8'h25
`define LCDHP_A_GAMMA_C3           8'h26
`define LCDHP_A_GAMMA_C4           8'h27
`define LCDHP_A_PRECHARGE_DIR      8'h28
`define LCDHP_A_GAMMA_DISCONNECT   8'h2a
`define LCDHP_A_CALIBRATION        8'h2d
`define LCDHP_A_PRECHARGE_EXTRA    8'h2e
`define LCDHP_A_GP_OUT             8'h31
`define LCDHP_A_GP_IN              8'h32
`define LCDHP_A_BUS_VOLT           8'h72
`define LCDHP_A_CORE_VOLT          8'h73

// ****************************************
// Field positions and values
// ****************************************
`define LCDHP_BUS_WIDTH_BIT        7
`define LCDHP_CMD_RESET_BIT        0
`define LCDHP_RST_PRECHARGE_EXTRA  8'h06
`define LCDHP_RST_INDEX            8'h00
`define LCDHP_WO_READ_VALUE        8'hff
`define LCDHP_SER_BITS             4'h8

`endif

// ==== lcdhp_host_model.sv ====
// Host CPU model that drives the command port pins in all three bus modes
module lcdhp_host_model (
	// Clock and bus mode
	input  wire logic        clk_sys,
	input  wire logic [1:0]  if_sel,
	// Bus pins
	output logic             cs_n,
	output logic             rs,
	output logic             rd_n_en,
	output logic             wr_n_dir,
	output logic [15:0]      db_in,
	input  wire logic [15:0] db_out,
	output logic             ser_clk,
	output logic             ser_data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cs_n = 1'b1;
		rs = 1'b0;
		rd_n_en = 1'b1;
		wr_n_dir = 1'b1;
		db_in = 16'h0000;
		ser_clk = 1'b0;
		ser_data = 1'b0;
	end

	// ********
	// Bus cycles
	// ********
	// Idle levels differ per mode: the enable line rests low, the strobes rest high
	task idle;
		cs_n = 1'b1;
		rd_n_en = (if_sel != 2'h1);
		wr_n_dir = 1'b1;
		ser_clk = 1'b0;
	endtask

	// Serial clock stands still low outside the frame
	task sbyte(input logic r, input logic [7:0] b);
		int i;
		@(negedge clk_sys);
		cs_n = 1'b0;
		for (i = 7; i >= 0; i--) begin
			@(negedge clk_sys);
			ser_clk = 1'b0;
			ser_data = b[i];
			rs = r;
			@(negedge clk_sys);
			ser_clk = 1'b1;
		end
		@(negedge clk_sys);
		ser_clk = 1'b0;
		ser_data = ~b[0];
		repeat (2) @(negedge clk_sys);
		cs_n = 1'b1;
	endtask

	task wr(input logic r, input logic [15:0] d);
		if (if_sel == 2'h2) begin
			sbyte(r, d[7:0]);
		end else begin
			@(negedge clk_sys);
			cs_n = 1'b0;
			rs = r;
			db_in = d;
			wr_n_dir = 1'b0;
			// Read strobe stays high in strobe mode; enable rises in enable mode
			rd_n_en = 1'b1;
			@(negedge clk_sys);
			if (if_sel == 2'h1) rd_n_en = 1'b0;
			else wr_n_dir = 1'b1;
			@(negedge clk_sys);
			cs_n = 1'b1;
			db_in = ~d;
		end
	endtask

	task rd(output logic [15:0] d);
		@(negedge clk_sys);
		cs_n = 1'b0;
		rs = 1'b1;
		wr_n_dir = 1'b1;
		rd_n_en = (if_sel == 2'h1);
		repeat (3) @(negedge clk_sys);
		d = db_out;
		rd_n_en = ~rd_n_en;
		cs_n = 1'b1;
	endtask
endmodule

// ==== lcdhp_pkg.sv ====
// Types shared by the host command port modules
package lcdhp_pkg;

	typedef enum logic [1:0] {
		LCDHP_IF_STROBE,
		LCDHP_IF_ENABLE,
		LCDHP_IF_SERIAL
	} lcdhp_if_e;

	typedef enum logic [1:0] {
		LCDHP_K_UNUSED,
		LCDHP_K_RW,
		LCDHP_K_RO,
		LCDHP_K_WO
	} lcdhp_kind_e;

	typedef logic [127:0][7:0] lcdhp_regs_t;

	typedef struct packed {
		logic [7:0]  shift;
		logic [3:0]  count;
		logic        clk_prev;
		logic [7:0]  data;
		logic        rs;
		logic        valid;
	} lcdhp_ser_s;

endpackage

// ==== lcdhp_port.sv ====
// Host command port: bus cycle decoding, index and register file, pixel data pairing
// ****************************************
// ****************************************
`include "lcdhp_defs.svh"

module lcdhp_port
	import lcdhp_pkg::*;
#(
	parameter int IN_W = 4
)(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	// Interface selection
	input  wire logic [1:0]        if_sel,
	// Parallel bus
	input  wire logic              cs_n,
	input  wire logic              register_select_line,
	input  wire logic              rd_n_en,
	input  wire logic              wr_n_dir,
	input  wire logic [15:0]       db_in,
	output logic      [15:0]       db_out,
	output logic      [15:0]       db_oe,
	// Serial link
	input  wire logic              ser_clk,
	input  wire logic              ser_data,
	// Block side
	input  wire logic [IN_W-1:0]   gp_in,
	output logic      [7:0]        control_one,
	output logic      [7:0]        control_two,
	output logic      [7:0]        data_access_control,
	output logic      [7:0]        gp_out,
	output logic      [15:0]       pixel_data,
	output logic                   pixel_stb,
	output logic                   command_reset_stb,
	output logic      [7:0]        register_pointer
);

	if (IN_W < 1 || IN_W > 8) begin : g_chk
		$error("IN_W must lie between 1 and 8");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		lcdhp_regs_t regs;
		logic [7:0]  ptr;
		logic        cs_prev;
		logic        rs_prev;
		logic        rd_prev;
		logic        wr_prev;
		logic [15:0] db_prev;
		logic        half;
		logic [7:0]  hi_byte;
		logic [15:0] pix;
		logic        pix_stb;
		logic        command_reset_bit_stb;
		logic [15:0] rdata;
		logic        oe;
	} lcdhp_port_s;

	lcdhp_port_s st_r;
	lcdhp_port_s st_nxt;

	lcdhp_byte_if ser_byte ();

	lcdhp_serial_rx u_ser (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.cs_n     (cs_n),
		.ser_clk  (ser_clk),
		.ser_data (ser_data),
		.rs       (register_select_line),
		.byte_o   (ser_byte.src)
	);

	// ****************************************
	// Functions
	// ****************************************
	function automatic lcdhp_kind_e reg_kind(input logic [7:0] a);
		case (a)
			`LCDHP_A_CMD_RESET,
			`LCDHP_A_PIXEL_PORT:       reg_kind = LCDHP_K_WO;
			`LCDHP_A_GP_IN:            reg_kind = LCDHP_K_RO;
			`LCDHP_A_CONTROL_ONE,
			`LCDHP_A_CONTROL_TWO,
			`LCDHP_A_DATA_ACCESS,
			`LCDHP_A_COLUMN_PTR,
			`LCDHP_A_LINE_PTR,
			`LCDHP_A_WIN_COL_LOW,
			`LCDHP_A_WIN_COL_HIGH,
			`LCDHP_A_WIN_LINE_LOW,
			`LCDHP_A_WIN_LINE_HIGH,
			`LCDHP_A_SCROLL_FIRST,
			`LCDHP_A_SCROLL_TOTAL,
			`LCDHP_A_SCROLL_STEP,
			`LCDHP_A_BLANK_COLOUR,
			`LCDHP_A_PART1_FIRST,
			`LCDHP_A_PART2_FIRST,
			`LCDHP_A_PART1_TOTAL,
			`LCDHP_A_PART2_TOTAL,
			`LCDHP_A_SUPPLY_ONE,
			`LCDHP_A_SUPPLY_TWO,
			`LCDHP_A_COMMON_CENTRE,
			`LCDHP_A_DRIVE_STRENGTH,
			`LCDHP_A_GAMMA_REF,
			`LCDHP_A_GAMMA_C1,
			`LCDHP_A_GAMMA_C2,
			`LCDHP_A_GAMMA_C3,
			`LCDHP_A_GAMMA_C4,
			`LCDHP_A_PRECHARGE_DIR,
			`LCDHP_A_GAMMA_DISCONNECT,
			`LCDHP_A_CALIBRATION,
			`LCDHP_A_PRECHARGE_EXTRA,
			`LCDHP_A_GP_OUT,
			`LCDHP_A_BUS_VOLT,
			`LCDHP_A_CORE_VOLT:        reg_kind = LCDHP_K_RW;
			default:                   reg_kind = LCDHP_K_UNUSED;
		endcase
	endfunction

	function automatic lcdhp_regs_t default_regs();
		lcdhp_regs_t r;
		r = '0;
		r[`LCDHP_A_PRECHARGE_EXTRA] = `LCDHP_RST_PRECHARGE_EXTRA;
		default_regs = r;
	endfunction

	localparam lcdhp_regs_t REGS_RST = default_regs();

	function automatic logic [7:0] read_value(input logic [7:0] a, input lcdhp_regs_t r,
		input logic [IN_W-1:0] gpi);
		read_value = 8'h00;
		case (reg_kind(a))
			LCDHP_K_RW:     read_value = r[a[6:0]];
			LCDHP_K_RO:     read_value = 8'(gpi);
			// Reads of write-only slots carry no meaning; a fixed pattern keeps them deterministic
			LCDHP_K_WO:     read_value = `LCDHP_WO_READ_VALUE;
			LCDHP_K_UNUSED: read_value = 8'h00;
			default:        read_value = 8'h00;
		endcase
	endfunction

	// ****************************************
	// Bus cycle decoding
	// ****************************************
	lcdhp_if_e    mode;
	logic         wide;
	logic         wr_ev;
	logic         wr_rs;
	logic [15:0]  wr_data;
	logic         rd_act;

	assign mode = lcdhp_if_e'(if_sel);
	// Width applies to the parallel buses only
	assign wide = (mode != LCDHP_IF_SERIAL) &&
		!st_r.regs[`LCDHP_A_DATA_ACCESS][`LCDHP_BUS_WIDTH_BIT];

	always_comb begin
		wr_ev   = 1'b0;
		wr_rs   = st_r.rs_prev;
		wr_data = st_r.db_prev;
		rd_act  = 1'b0;
		case (mode)
			LCDHP_IF_STROBE: begin
				// Write taken at the rising edge of the low write pulse, data from the last low cycle
				wr_ev  = !st_r.cs_prev && !st_r.wr_prev && wr_n_dir;
				rd_act = !cs_n && !rd_n_en && register_select_line;
			end
			LCDHP_IF_ENABLE: begin
				// Enable falling edge ends the high pulse; direction low means write
				wr_ev  = !st_r.cs_prev && st_r.rd_prev && !rd_n_en && !st_r.wr_prev;
				rd_act = !cs_n && rd_n_en && wr_n_dir && register_select_line;
			end
			LCDHP_IF_SERIAL: begin
				// Serial path is write-only; a byte carries the select level of its last bit
				wr_ev   = ser_byte.valid;
				wr_rs   = ser_byte.rs;
				wr_data = {8'h00, ser_byte.data};
			end
			default: begin
				wr_ev = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Command execution
	// ****************************************
	always_comb begin
		st_nxt          = st_r;
		st_nxt.cs_prev  = cs_n;
		st_nxt.rs_prev  = register_select_line;
		st_nxt.rd_prev  = rd_n_en;
		st_nxt.wr_prev  = wr_n_dir;
		st_nxt.db_prev  = db_in;
		st_nxt.pix_stb  = 1'b0;
		st_nxt.command_reset_bit_stb = 1'b0;
		if (wr_ev) begin
			if (!wr_rs) begin
				// Upper lines are don't-care for the pointer
				st_nxt.ptr  = wr_data[7:0];
				st_nxt.half = 1'b0;
			end else if (st_r.ptr == `LCDHP_A_PIXEL_PORT) begin
				if (wide) begin
					st_nxt.pix     = wr_data;
					st_nxt.pix_stb = 1'b1;
				end else if (!st_r.half) begin
					st_nxt.hi_byte = wr_data[7:0];
					st_nxt.half    = 1'b1;
				end else begin
					st_nxt.pix     = {st_r.hi_byte, wr_data[7:0]};
					st_nxt.pix_stb = 1'b1;
					st_nxt.half    = 1'b0;
				end
			end else if (st_r.ptr == `LCDHP_A_CMD_RESET) begin
				if (wr_data[`LCDHP_CMD_RESET_BIT]) begin
					// The reset bit is never stored; reads of this write-only slot return the fixed pattern 8'hff
					st_nxt.regs     = default_regs();
					st_nxt.ptr      = `LCDHP_RST_INDEX;
					st_nxt.half     = 1'b0;
					st_nxt.command_reset_bit_stb = 1'b1;
				end
			end else if (reg_kind(st_r.ptr) == LCDHP_K_RW) begin
				// One-byte command whatever the width; completes this cycle, no busy state
				st_nxt.regs[st_r.ptr[6:0]] = wr_data[7:0];
			end
		end
		st_nxt.oe    = rd_act;
		st_nxt.rdata = {8'h00, read_value(st_r.ptr, st_r.regs, gp_in)};
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_r      <= '0;
			st_r.regs <= REGS_RST;
			st_r.cs_prev <= 1'b1;
			st_r.rd_prev <= 1'b1;
			st_r.wr_prev <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign db_out              = st_r.oe ? st_r.rdata : 16'h0000;
	assign db_oe               = {16{st_r.oe}};
	assign control_one         = st_r.regs[`LCDHP_A_CONTROL_ONE];
	assign control_two         = st_r.regs[`LCDHP_A_CONTROL_TWO];
	assign data_access_control = st_r.regs[`LCDHP_A_DATA_ACCESS];
	assign gp_out              = st_r.regs[`LCDHP_A_GP_OUT];
	assign pixel_data          = st_r.pix;
	assign pixel_stb           = st_r.pix_stb;
	assign command_reset_stb   = st_r.command_reset_bit_stb;
	assign register_pointer    = st_r.ptr;

	// ****************************************
	// Checks
	// ****************************************
	property p_ptr_load;
		@(posedge clk_sys) disable iff (!resetn)
		(wr_ev && !wr_rs) |=> (register_pointer == $past(wr_data[7:0]));
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded by select-low write");

	property p_reg_write;
		@(posedge clk_sys) disable iff (!resetn)
		(wr_ev && wr_rs && st_r.ptr == `LCDHP_A_CONTROL_ONE) |=> (control_one == $past(wr_data[7:0]));
	endproperty
	a_reg_write: assert property (p_reg_write) else $error("register write not complete next cycle");

	property p_upper_ignored;
		@(posedge clk_sys) disable iff (!resetn)
		(wr_ev && wr_rs && wide && st_r.ptr == `LCDHP_A_GP_OUT) |=> (gp_out == $past(wr_data[7:0]));
	endproperty
	a_upper_ignored: assert property (p_upper_ignored) else $error("upper data lines reached a register");

	property p_pix_wide;
		@(posedge clk_sys) disable iff (!resetn)
		(wr_ev && wr_rs && wide && st_r.ptr == `LCDHP_A_PIXEL_PORT) |=>
			(pixel_stb && pixel_data == $past(wr_data));
	endproperty
	a_pix_wide: assert property (p_pix_wide) else $error("wide pixel word not passed in one transfer");

	property p_pix_pair;
		@(posedge clk_sys) disable iff (!resetn)
		(wr_ev && wr_rs && !wide && st_r.ptr == `LCDHP_A_PIXEL_PORT && st_r.half) |=>
			(pixel_stb && pixel_data == {$past(st_r.hi_byte), $past(wr_data[7:0])});
	endproperty
	a_pix_pair: assert property (p_pix_pair) else $error("narrow pixel bytes not paired high first");

	property p_pix_first_half;
		@(posedge clk_sys) disable iff (!resetn)
		(wr_ev && wr_rs && !wide && st_r.ptr == `LCDHP_A_PIXEL_PORT && !st_r.half) |=> !pixel_stb;
	endproperty
	a_pix_first_half: assert property (p_pix_first_half) else $error("pixel emitted after one narrow byte");

	property p_command_reset_bit_pulse;
		@(posedge clk_sys) disable iff (!resetn)
		command_reset_stb |=> !command_reset_stb && register_pointer == `LCDHP_RST_INDEX ##1 !command_reset_stb;
	endproperty
	a_command_reset_bit_pulse: assert property (p_command_reset_bit_pulse) else $error("command reset not self-clearing");

	property p_unused_zero;
		@(posedge clk_sys) disable iff (!resetn)
		(rd_act && reg_kind(st_r.ptr) == LCDHP_K_UNUSED && $stable(st_r.ptr)) |=> (db_out == 16'h0000 && db_oe[0]);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused register read not zero");

	property p_strobe_write;
		@(posedge clk_sys) disable iff (!resetn)
		(mode == LCDHP_IF_STROBE && !cs_n && !wr_n_dir ##1 (wr_n_dir && $stable(mode))) |-> wr_ev;
	endproperty
	a_strobe_write: assert property (p_strobe_write) else $error("write strobe rise not taken");

	property p_enable_write;
		@(posedge clk_sys) disable iff (!resetn)
		(mode == LCDHP_IF_ENABLE && !cs_n && rd_n_en && !wr_n_dir ##1 (!rd_n_en && $stable(mode))) |-> wr_ev;
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable pulse write not taken");

	c_pix_pair:  cover property (@(posedge clk_sys) disable iff (!resetn) pixel_stb && !wide);
	c_pix_wide:  cover property (@(posedge clk_sys) disable iff (!resetn) pixel_stb && wide);
	c_command_reset_bit:      cover property (@(posedge clk_sys) disable iff (!resetn) command_reset_stb);
	c_ser_write: cover property (@(posedge clk_sys) disable iff (!resetn) wr_ev && mode == LCDHP_IF_SERIAL);

endmodule

// ==== lcdhp_serial_rx.sv ====
// Serial byte assembler of the host command port, MSB first
`include "lcdhp_defs.svh"

module lcdhp_serial_rx
	import lcdhp_pkg::*;
(
	// Clock and reset
	input  wire logic   clk_sys,
	input  wire logic   resetn,
	// Serial pins
	input  wire logic   cs_n,
	input  wire logic   ser_clk,
	input  wire logic   ser_data,
	input  wire logic   rs,
	// Assembled bytes
	lcdhp_byte_if.src   byte_o
);

	lcdhp_ser_s st_r;
	lcdhp_ser_s st_nxt;

	always_comb begin
		st_nxt          = st_r;
		st_nxt.valid    = 1'b0;
		st_nxt.clk_prev = ser_clk;
		if (cs_n) begin
			// Deselect drops a partial byte so the next frame starts aligned
			st_nxt.count = 4'h0;
		end else if (ser_clk && !st_r.clk_prev) begin
			st_nxt.shift = {st_r.shift[6:0], ser_data};
			st_nxt.count = st_r.count + 4'h1;
			if (st_r.count == `LCDHP_SER_BITS - 4'h1) begin
				st_nxt.count = 4'h0;
				st_nxt.data  = {st_r.shift[6:0], ser_data};
				st_nxt.rs    = rs;
				st_nxt.valid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign byte_o.data  = st_r.data;
	assign byte_o.rs    = st_r.rs;
	assign byte_o.valid = st_r.valid;

	// ****************************************
	// Checks
	// ****************************************
	property p_ser_msb_first;
		@(posedge clk_sys) disable iff (!resetn)
		st_nxt.valid |=> (st_r.data[0] == $past(ser_data)) && (st_r.data[7:1] == $past(st_r.shift[6:0]));
	endproperty
	a_ser_msb_first: assert property (p_ser_msb_first) else $error("serial byte not assembled MSB first");

endmodule
